//--- hw/dac_register_write_decode.sv
// serial command decoder for the dac level registers of four measurement channels
// assumes the host frames 29-bit words with sync_n_i low and spaces frames by a few system clocks
`timescale 1ns/10ps
module dac_register_write_decode #(
  parameter int NUM_CH = dac_decode_pkg::NUM_CH
) (
  input  wire logic                                     clk_sys_i,         // system clock, 40 MHz
  input  wire logic                                     reset_n_i,         // async reset, active low
  input  wire logic                                     sclk_link_i,       // serial link clock
  input  wire logic                                     sync_n_i,          // frame select, active low
  input  wire logic                                     sdi_i,             // serial data in, msb first
  input  wire logic [NUM_CH-1:0]                        force_voltage_i,   // per channel force voltage mode
  input  wire logic [dac_decode_pkg::RB_W-1:0]          sys_ctrl_i,        // system control readback value
  input  wire logic [dac_decode_pkg::RB_W-1:0]          cmp_status_i,      // comparator status value
  input  wire logic [dac_decode_pkg::RB_W-1:0]          alarm_status_i,    // alarm status value
  input  wire logic [NUM_CH-1:0][dac_decode_pkg::RB_W-1:0] chan_reg_i,     // channel register values
  output logic                                          ctrl_wr_o,         // control register write pulse
  output logic [NUM_CH-1:0]                             ctrl_chan_o,       // channels of that write
  output logic [21:0]                                   ctrl_data_o,       // control write payload
  output logic [dac_decode_pkg::DATA_W-1:0]             offset_dac_code_o, // shared offset dac code
  output logic                                          offset_dac_load_o, // shared offset dac load pulse
  output dac_decode_pkg::dac_triple_s [NUM_CH-1:0]      clamp_low_o,       // low clamp triples
  output dac_decode_pkg::dac_triple_s [NUM_CH-1:0]      clamp_high_o,      // high clamp triples
  output logic [NUM_CH-1:0]                             recalc_o,          // corrected code recompute pulses
  output logic [NUM_CH-1:0][dac_decode_pkg::SLOT_W-1:0] recalc_slot_o,     // slot to recompute
  output dac_decode_pkg::readback_s                     readback_o         // readback answer
);
  import dac_decode_pkg::*;

  localparam int CH_IDX_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  if (NUM_CH != 4) begin : g_bad_ch
    $error("dac_register_write_decode: word carries exactly four channel bits");
  end

  // ------------------------------------------------------------
  // link domain: shift in one frame
  // ------------------------------------------------------------
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [WORD_W-2:0] shift_r;
  logic [WORD_W-1:0] frame_r;
  logic              frame_tgl_r;

  // the link clock stops between frames, so the frame select clears the count itself
  always_ff @(posedge sclk_link_i or posedge sync_n_i) begin
    if (sync_n_i) begin
      bit_cnt_r <= '0;
    end else if (bit_cnt_r != FRAME_DONE) begin
      bit_cnt_r <= bit_cnt_r + 5'h01;
    end
  end

  // the shift stops after 28 bits; the last bit goes straight into the frame word
  always_ff @(posedge sclk_link_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_r <= '0;
    end else if (bit_cnt_r < FRAME_LAST) begin
      shift_r <= {shift_r[WORD_W-3:0], sdi_i};
    end
  end

  // word and toggle change on the same edge; the word is then stable for a whole frame
  always_ff @(posedge sclk_link_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_r     <= '0;
      frame_tgl_r <= 1'b0;
    end else if (bit_cnt_r == FRAME_LAST) begin
      frame_r     <= {shift_r, sdi_i};
      frame_tgl_r <= ~frame_tgl_r;
    end
  end

  chk_frame_complete: assert property (@(posedge sclk_link_i) disable iff (!reset_n_i)
    $changed(frame_tgl_r) |-> $past(bit_cnt_r) == FRAME_LAST && !$past(sync_n_i))
    else $error("frame taken before 29 bits");

  // ------------------------------------------------------------
  // system domain: reset release and frame event crossing
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  logic      tgl_meta_r;
  logic      tgl_sync_r;
  logic      tgl_seen_r;
  logic      cmd_vld_r;
  cmd_word_s cmd_r;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= frame_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      cmd_vld_r <= 1'b0;
      cmd_r     <= '0;
    end else begin
      cmd_vld_r <= tgl_sync_r ^ tgl_seen_r;
      if (tgl_sync_r ^ tgl_seen_r) begin
        cmd_r <= cmd_word_s'(frame_r);
      end
    end
  end

  // ------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------
  logic [SLOT_W:0]   slot_dec;
  logic              slot_ok;
  logic [SLOT_W-1:0] slot;
  logic              is_write;
  logic              is_read;
  logic              to_offset_dac;

  assign slot_dec      = decode_slot(cmd_r.addr);
  assign slot_ok       = slot_dec[SLOT_W];
  assign slot          = slot_dec[SLOT_W-1:0];
  assign is_write      = cmd_vld_r && !cmd_r.dir;
  assign is_read       = cmd_vld_r && cmd_r.dir;
  assign to_offset_dac = cmd_r.kind == KIND_INPUT && cmd_r.addr == ADDR_OFFSET_DAC;

  // ------------------------------------------------------------
  // per channel banks
  // ------------------------------------------------------------
  bank_wr_s [NUM_CH-1:0]              bank_wr;
  logic [NUM_CH-1:0]                  bank_en;
  logic [NUM_CH-1:0][DATA_W-1:0]      bank_rd;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_bank
    // every selected channel gets the same strobe in the same cycle
    assign bank_en[g] = is_write && cmd_r.chan[g] && cmd_r.kind != KIND_CTRL && slot_ok;
    assign bank_wr[g] = '{en: bank_en[g], kind: cmd_r.kind, slot: slot, data: cmd_r.data};

    dac_channel_bank #(
      .NUM_SLOTS (NUM_SLOT)
    ) u_bank (
      .clk_sys_i       (clk_sys_i),
      .rst_n_i         (rst_n),
      .wr_i            (bank_wr[g]),
      .force_voltage_i (force_voltage_i[g]),
      .rd_kind_i       (cmd_r.kind),
      .rd_slot_i       (slot),
      .rd_data_o       (bank_rd[g]),
      .clamp_low_o     (clamp_low_o[g]),
      .clamp_high_o    (clamp_high_o[g]),
      .recalc_o        (recalc_o[g]),
      .recalc_slot_o   (recalc_slot_o[g])
    );
  end

  // ------------------------------------------------------------
  // shared offset dac and control writes
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      offset_dac_code_o <= '0;
      offset_dac_load_o <= 1'b0;
    end else begin
      offset_dac_load_o <= is_write && to_offset_dac && cmd_r.chan != '0;
      if (is_write && to_offset_dac && cmd_r.chan != '0) begin
        offset_dac_code_o <= cmd_r.data;
      end
    end
  end

  // control and channel register contents live elsewhere; only the strobe, its channels and its payload are made here
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_wr_o   <= 1'b0;
      ctrl_chan_o <= '0;
      ctrl_data_o <= '0;
    end else begin
      ctrl_wr_o <= is_write && cmd_r.kind == KIND_CTRL;
      if (is_write && cmd_r.kind == KIND_CTRL) begin
        ctrl_chan_o <= cmd_r.chan;
        ctrl_data_o <= {cmd_r.addr, cmd_r.data};
      end
    end
  end

  // ------------------------------------------------------------
  // readback source selection
  // ------------------------------------------------------------
  logic [CH_IDX_W-1:0] rd_ch;
  logic                chan_single;
  rb_src_e             rd_src;
  logic [RB_W-1:0]     rd_data;

  always_comb begin
    rd_ch = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      if (cmd_r.chan[i]) begin
        rd_ch = CH_IDX_W'(i);
      end
    end
  end

  // only one channel register may be read at a time
  assign chan_single = cmd_r.chan != '0 && (cmd_r.chan & (cmd_r.chan - 1'b1)) == '0;

  always_comb begin
    rd_src  = RB_NONE;
    rd_data = '0;
    if (cmd_r.chan == '0) begin
      case (cmd_r.kind)
        KIND_CTRL: begin
          rd_src  = RB_SYS_CTRL;
          rd_data = sys_ctrl_i;
        end
        KIND_GAIN: begin
          rd_src  = RB_CMP_STATUS;
          rd_data = cmp_status_i;
        end
        KIND_INPUT: begin
          rd_src  = RB_ALARM;
          rd_data = alarm_status_i;
        end
        default: ;
      endcase
    end else if (chan_single) begin
      if (cmd_r.kind == KIND_CTRL) begin
        rd_src  = RB_CHAN_REG;
        rd_data = chan_reg_i[rd_ch];
      end else if (to_offset_dac) begin
        rd_src  = RB_DAC;
        rd_data = {8'h00, offset_dac_code_o};
      end else if (slot_ok) begin
        rd_src  = RB_DAC;
        rd_data = {8'h00, bank_rd[rd_ch]};
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      readback_o <= '0;
    end else begin
      readback_o.valid <= is_read;
      if (is_read) begin
        readback_o.src  <= rd_src;
        readback_o.data <= rd_data;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_read_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_read |-> bank_en == '0 ##1 !offset_dac_load_o && !ctrl_wr_o)
    else $error("readback request changed a register");

  chk_read_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_read && cmd_r.chan == '0 && cmd_r.kind == KIND_INPUT
    |=> readback_o.valid && readback_o.src == RB_ALARM && readback_o.data == $past(alarm_status_i))
    else $error("alarm status readback wrong");

  chk_read_dac_src: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_read && chan_single && cmd_r.kind != KIND_CTRL && slot_ok
    |=> readback_o.src == RB_DAC && readback_o.data[DATA_W-1:0] == $past(bank_rd[rd_ch]))
    else $error("dac readback not decoded like a write");

  chk_chan_mask: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && cmd_r.kind != KIND_CTRL && slot_ok |-> bank_en == cmd_r.chan)
    else $error("channel strobes differ from select bits");

  chk_multi_same: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    bank_en[0] && bank_en[NUM_CH-1] |-> bank_wr[0] == bank_wr[NUM_CH-1])
    else $error("multichannel write not identical");

  chk_reserved_drop: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && !slot_ok |-> bank_en == '0)
    else $error("reserved dac address wrote storage");

  chk_offset_dac: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    offset_dac_load_o |-> $past(cmd_r.kind) == KIND_INPUT && $past(cmd_r.addr) == ADDR_OFFSET_DAC
                          && offset_dac_code_o == $past(cmd_r.data))
    else $error("shared offset dac loaded from wrong command");

  chk_frame_to_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    tgl_sync_r != tgl_seen_r |=> cmd_vld_r ##1 !cmd_vld_r)
    else $error("frame event not turned into one command");

  // ------------------------------------------------------------
  // checks on strobes, recompute pulses and system control and channel register reads
  // ------------------------------------------------------------
  // each looks one cycle after the command, where the registered outputs settle

  chk_ctrl_strobe: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && cmd_r.kind == KIND_CTRL
    |=> ctrl_wr_o && ctrl_chan_o == $past(cmd_r.chan) && ctrl_data_o[DATA_W-1:0] == $past(cmd_r.data))
    else $error("control write strobe or payload wrong");

  chk_dac_no_ctrl: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && cmd_r.kind != KIND_CTRL |=> !ctrl_wr_o)
    else $error("dac write raised the control strobe");

  chk_no_recalc: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && cmd_r.kind != KIND_INPUT |=> recalc_o == '0)
    else $error("recompute after a gain, offset or control write");

  chk_recalc_all: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && cmd_r.kind == KIND_INPUT && slot_ok |=> recalc_o == $past(cmd_r.chan))
    else $error("input code load missed a selected channel");

  chk_recalc_slot: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && cmd_r.kind == KIND_INPUT && slot_ok && cmd_r.chan[0]
    |=> recalc_slot_o[0] == $past(slot))
    else $error("recompute slot differs from decoded address");

  chk_read_sys: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_read && cmd_r.chan == '0 && cmd_r.kind == KIND_CTRL
    |=> readback_o.src == RB_SYS_CTRL && readback_o.data == $past(sys_ctrl_i))
    else $error("system control readback wrong");

  chk_read_chan_reg: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_read && chan_single && cmd_r.kind == KIND_CTRL
    |=> readback_o.src == RB_CHAN_REG && readback_o.data == $past(chan_reg_i[rd_ch]))
    else $error("channel register readback wrong");

  // the shared dac needs at least one channel bit; a write with all channel bits zero is dropped
  chk_offset_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
    is_write && to_offset_dac && cmd_r.chan != '0 |=> offset_dac_load_o)
    else $error("shared offset dac write not taken");

endmodule

//--- inc/dac_decode_pkg.sv
// shared constants, types and the dac address decode for the dac register write decoder
// assumes a 29-bit serial command word with fixed field positions and four channels
package dac_decode_pkg;

  // ------------------------------------------------------------
  // word layout and sizes
  // ------------------------------------------------------------
  localparam int NUM_CH   = 4;
  localparam int WORD_W   = 29;
  localparam int DATA_W   = 16;
  localparam int GAIN_W   = 15;
  localparam int RB_W     = 24;
  localparam int NUM_SLOT = 22;
  localparam int SLOT_W   = 5;
  localparam int CNT_W    = 5;

  localparam logic [CNT_W-1:0] FRAME_LAST = 5'h1C;
  localparam logic [CNT_W-1:0] FRAME_DONE = 5'h1D;

  // ------------------------------------------------------------
  // dac addresses and storage slots
  // ------------------------------------------------------------
  localparam logic [5:0] ADDR_OFFSET_DAC    = 6'h00;
  localparam logic [5:0] ADDR_FORCE_BASE    = 6'h08;
  localparam logic [5:0] ADDR_CLAMP_LO_CUR  = 6'h14;
  localparam logic [5:0] ADDR_CLAMP_LO_VOLT = 6'h15;
  localparam logic [5:0] ADDR_CLAMP_HI_CUR  = 6'h1C;
  localparam logic [5:0] ADDR_CLAMP_HI_VOLT = 6'h1D;
  localparam logic [5:0] ADDR_CMP_LO_BASE   = 6'h20;
  localparam logic [5:0] ADDR_CMP_HI_BASE   = 6'h28;
  localparam logic [2:0] RANGE_LAST         = 3'h5;

  localparam logic [SLOT_W-1:0] SLOT_FORCE         = 5'h00;
  localparam logic [SLOT_W-1:0] SLOT_CLAMP_LO_CUR  = 5'h06;
  localparam logic [SLOT_W-1:0] SLOT_CLAMP_LO_VOLT = 5'h07;
  localparam logic [SLOT_W-1:0] SLOT_CLAMP_HI_CUR  = 5'h08;
  localparam logic [SLOT_W-1:0] SLOT_CLAMP_HI_VOLT = 5'h09;
  localparam logic [SLOT_W-1:0] SLOT_CMP_LO        = 5'h0A;
  localparam logic [SLOT_W-1:0] SLOT_CMP_HI        = 5'h10;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_CTRL  = 2'b00,
    KIND_GAIN  = 2'b01,
    KIND_OFFS  = 2'b10,
    KIND_INPUT = 2'b11
  } reg_kind_e;

  typedef enum logic [2:0] {
    RB_NONE       = 3'b000,
    RB_SYS_CTRL   = 3'b001,
    RB_CMP_STATUS = 3'b010,
    RB_ALARM      = 3'b011,
    RB_CHAN_REG   = 3'b100,
    RB_DAC        = 3'b101
  } rb_src_e;

  typedef struct packed {
    logic              dir;
    logic [NUM_CH-1:0] chan;
    reg_kind_e         kind;
    logic [5:0]        addr;
    logic [DATA_W-1:0] data;
  } cmd_word_s;

  typedef struct packed {
    logic [DATA_W-1:0] input_code;
    logic [GAIN_W-1:0] gain;
    logic [DATA_W-1:0] offset;
  } dac_triple_s;

  typedef struct packed {
    logic              en;
    reg_kind_e         kind;
    logic [SLOT_W-1:0] slot;
    logic [DATA_W-1:0] data;
  } bank_wr_s;

  typedef struct packed {
    logic            valid;
    rb_src_e         src;
    logic [RB_W-1:0] data;
  } readback_s;

  // returns {hit, slot}; anything outside the table misses
  function automatic logic [SLOT_W:0] decode_slot(input logic [5:0] addr);
    logic [SLOT_W:0] res;
    res = '0;
    if (addr[5:3] == ADDR_FORCE_BASE[5:3] && addr[2:0] <= RANGE_LAST) begin
      res = {1'b1, SLOT_FORCE + {2'b00, addr[2:0]}};
    end else if (addr[5:3] == ADDR_CMP_LO_BASE[5:3] && addr[2:0] <= RANGE_LAST) begin
      res = {1'b1, SLOT_CMP_LO + {2'b00, addr[2:0]}};
    end else if (addr[5:3] == ADDR_CMP_HI_BASE[5:3] && addr[2:0] <= RANGE_LAST) begin
      res = {1'b1, SLOT_CMP_HI + {2'b00, addr[2:0]}};
    end else if (addr == ADDR_CLAMP_LO_CUR) begin
      res = {1'b1, SLOT_CLAMP_LO_CUR};
    end else if (addr == ADDR_CLAMP_LO_VOLT) begin
      res = {1'b1, SLOT_CLAMP_LO_VOLT};
    end else if (addr == ADDR_CLAMP_HI_CUR) begin
      res = {1'b1, SLOT_CLAMP_HI_CUR};
    end else if (addr == ADDR_CLAMP_HI_VOLT) begin
      res = {1'b1, SLOT_CLAMP_HI_VOLT};
    end
    return res;
  endfunction

endpackage

//--- hw/dac_channel_bank.sv
// one channel's dac input, gain and offset storage plus clamp set selection
// assumes write strobes and read selects arrive already decoded on the system clock
`timescale 1ns/10ps
module dac_channel_bank #(
  parameter int NUM_SLOTS = dac_decode_pkg::NUM_SLOT
) (
  input  wire logic                          clk_sys_i,       // system clock
  input  wire logic                          rst_n_i,         // synchronised reset, active low
  input  wire dac_decode_pkg::bank_wr_s      wr_i,            // decoded write strobe
  input  wire logic                          force_voltage_i, // channel forces voltage
  input  wire dac_decode_pkg::reg_kind_e     rd_kind_i,       // kind selected for readback
  input  wire logic [dac_decode_pkg::SLOT_W-1:0] rd_slot_i,   // slot selected for readback
  output logic [dac_decode_pkg::DATA_W-1:0]  rd_data_o,       // readback value
  output dac_decode_pkg::dac_triple_s        clamp_low_o,     // triple feeding the low clamp
  output dac_decode_pkg::dac_triple_s        clamp_high_o,    // triple feeding the high clamp
  output logic                               recalc_o,        // corrected code recompute pulse
  output logic [dac_decode_pkg::SLOT_W-1:0]  recalc_slot_o    // slot to recompute
);
  import dac_decode_pkg::*;

  if (NUM_SLOTS < NUM_SLOT) begin : g_bad_slots
    $error("dac_channel_bank: too few slots");
  end

  // ------------------------------------------------------------
  // storage, cleared at reset: nothing survives power loss
  // ------------------------------------------------------------
  logic [DATA_W-1:0] input_r [NUM_SLOTS];
  logic [GAIN_W-1:0] gain_r  [NUM_SLOTS];
  logic [DATA_W-1:0] offs_r  [NUM_SLOTS];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        input_r[i] <= '0;
        gain_r[i]  <= '0;
        offs_r[i]  <= '0;
      end
    end else if (wr_i.en) begin
      case (wr_i.kind)
        KIND_GAIN:  gain_r[wr_i.slot]  <= wr_i.data[DATA_W-1:1];
        KIND_OFFS:  offs_r[wr_i.slot]  <= wr_i.data;
        KIND_INPUT: input_r[wr_i.slot] <= wr_i.data;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // recompute request, input code loads only
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      recalc_o      <= 1'b0;
      recalc_slot_o <= '0;
    end else begin
      recalc_o <= wr_i.en && wr_i.kind == KIND_INPUT;
      if (wr_i.en && wr_i.kind == KIND_INPUT) begin
        recalc_slot_o <= wr_i.slot;
      end
    end
  end

  // ------------------------------------------------------------
  // clamp sets follow the force mode
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clamp_low_o  <= '0;
      clamp_high_o <= '0;
    end else if (force_voltage_i) begin
      clamp_low_o  <= '{input_r[SLOT_CLAMP_LO_CUR], gain_r[SLOT_CLAMP_LO_CUR], offs_r[SLOT_CLAMP_LO_CUR]};
      clamp_high_o <= '{input_r[SLOT_CLAMP_HI_CUR], gain_r[SLOT_CLAMP_HI_CUR], offs_r[SLOT_CLAMP_HI_CUR]};
    end else begin
      clamp_low_o  <= '{input_r[SLOT_CLAMP_LO_VOLT], gain_r[SLOT_CLAMP_LO_VOLT], offs_r[SLOT_CLAMP_LO_VOLT]};
      clamp_high_o <= '{input_r[SLOT_CLAMP_HI_VOLT], gain_r[SLOT_CLAMP_HI_VOLT], offs_r[SLOT_CLAMP_HI_VOLT]};
    end
  end

  always_comb begin
    case (rd_kind_i)
      KIND_GAIN:  rd_data_o = {gain_r[rd_slot_i], 1'b0};
      KIND_OFFS:  rd_data_o = offs_r[rd_slot_i];
      KIND_INPUT: rd_data_o = input_r[rd_slot_i];
      default:    rd_data_o = '0;
    endcase
  end

  chk_gain_store: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_i.en && wr_i.kind == KIND_GAIN |=> gain_r[$past(wr_i.slot)] == $past(wr_i.data[DATA_W-1:1]))
    else $error("gain register did not keep upper fifteen bits");

  chk_input_store: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_i.en && wr_i.kind == KIND_INPUT |=> input_r[$past(wr_i.slot)] == $past(wr_i.data))
    else $error("input code not stored");

  chk_recalc_cause: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    recalc_o |-> $past(wr_i.en) && $past(wr_i.kind) == KIND_INPUT)
    else $error("recompute without input code load");

  chk_clamp_select: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    force_voltage_i && wr_i.en && wr_i.kind == KIND_INPUT && wr_i.slot == SLOT_CLAMP_LO_CUR
    ##1 force_voltage_i && !wr_i.en |=> clamp_low_o.input_code == $past(wr_i.data, 2))
    else $error("low clamp not fed from current range set");

endmodule

//--- test/host_link.sv
// host side of the serial command link: frames 29-bit words
// assumes the decoder samples sdi on the rising link clock edge
`timescale 1ns/10ps
module host_link (
  output logic sclk_o,   // link clock, still between frames
  output logic sync_n_o, // frame select, active low
  output logic sdi_o     // serial data
);
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b0;
    sdi_o = 1'b0;
    // a rising select clears the link counter, which has no other reset
    #1 sync_n_o = 1'b1;
  end
  // whole frames only; the link clock runs inside them
  task automatic send(input logic [28:0] w);
    sync_n_o = 1'b0;
    for (int k = 28; k >= 0; k--) begin
      sdi_o = w[k];
      #24 sclk_o = 1'b1;
      #24 sclk_o = 1'b0;
    end
    #24 sync_n_o = 1'b1;
    sdi_o = ~w[0]; // released line shows no stale bit
  endtask
endmodule

//--- test/tb.sv
// self-checking bench for the dac register write decoder
// assumes host_link frames the words and a 40 MHz system clock
`timescale 1ns/10ps
module tb;
  import dac_decode_pkg::*;
  logic              clk_sys_i, reset_n_i, sclk, sync_n, sdi, od_load, ctrl_wr;
  logic [3:0]        fv, rc, rc_seen, ctrl_ch;
  logic [23:0]       sc, cs, al;
  logic [3:0][23:0]  cr;
  logic [21:0]       ctrl_d;
  logic [1:0]        ev_seen;
  logic [15:0]       od_code;
  logic [3:0][4:0]   rcs, rcs_seen;
  dac_triple_s [3:0] cl, chh;
  readback_s         rb, rb_seen;
  int                n_errors, num_checks, seed, mi[4][22], mg[4][22], mo[4][22];
  host_link host_link_i (.sclk_o(sclk), .sync_n_o(sync_n), .sdi_o(sdi));
  dac_register_write_decode dac_register_write_decode_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .sclk_link_i(sclk), .sync_n_i(sync_n), .sdi_i(sdi), .force_voltage_i(fv), .sys_ctrl_i(sc),
    .cmp_status_i(cs), .alarm_status_i(al), .chan_reg_i(cr), .ctrl_wr_o(ctrl_wr), .ctrl_chan_o(ctrl_ch),
    .ctrl_data_o(ctrl_d), .offset_dac_code_o(od_code), .offset_dac_load_o(od_load), .clamp_low_o(cl),
    .clamp_high_o(chh), .recalc_o(rc), .recalc_slot_o(rcs), .readback_o(rb));
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // pulses last one cycle, so latch them for the later compare
  always @(posedge clk_sys_i) begin
    if (rc !== 4'h0) begin
      rc_seen <= rc;
      rcs_seen <= rcs;
    end
    if (rb.valid === 1'b1) rb_seen <= rb;
    if (od_load === 1'b1) ev_seen[0] <= 1'b1;
    if (ctrl_wr === 1'b1) ev_seen[1] <= 1'b1;
  end
  function automatic int sl(input int a);
    return a < 20 ? a - 8 : a < 28 ? a - 14 : a < 32 ? a - 20 : a - 22;
  endfunction
  task automatic chk(input string nm, input logic [46:0] seen, input logic [46:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [28:0] w);
    rc_seen = 4'h0;
    rb_seen = '0;
    ev_seen = 2'h0;
    host_link_i.send(w);
    repeat (12) @(posedge clk_sys_i);
    #2;
  endtask
  task automatic wr(input logic [3:0] m, input logic [1:0] k, input logic [5:0] a, input logic [15:0] d);
    for (int c = 0; c < 4; c++) if (m[c]) begin
      if (k == 2'h1) mg[c][sl(a)] = d[15:1];
      if (k == 2'h2) mo[c][sl(a)] = d;
      if (k == 2'h3) mi[c][sl(a)] = d;
    end
    cmd({1'b0, m, k, a, d});
    chk("recalc", rc_seen, k == 2'h3 ? m : 4'h0);
    chk("strobes", ev_seen, 2'h0);
  endtask
  task automatic rd(input logic [3:0] m, input logic [1:0] k, input logic [5:0] a, input logic [27:0] e);
    cmd({1'b1, m, k, a, 16'h0000});
    chk("readback", rb_seen, e);
  endtask
  task automatic clamps();
    for (int c = 0; c < 4; c++) begin
      chk("clamp_low", cl[c], {16'(mi[c][7-fv[c]]), 15'(mg[c][7-fv[c]]), 16'(mo[c][7-fv[c]])});
      chk("clamp_high", chh[c], {16'(mi[c][9-fv[c]]), 15'(mg[c][9-fv[c]]), 16'(mo[c][9-fv[c]])});
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    seed = 46;
    reset_n_i = 1'b1;
    fv = 4'h0;
    sc = 24'($random(seed));
    cs = 24'($random(seed));
    al = 24'($random(seed));
    // a clean falling edge, since the link side sees no clock during reset
    #1 reset_n_i = 1'b0;
    cr = {$random(seed), $random(seed), $random(seed)};
    repeat (10) @(posedge clk_sys_i);
    #2 reset_n_i = 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #2 clamps();
    for (int i = 0; i < 12; i++) begin
      fv = 4'($random(seed));
      wr(4'($random(seed)), 2'(i / 4 + 1), 6'h14 | {i[1], 3'h0} | i[0], 16'($random(seed)));
      clamps();
    end
    $display("test clamps done");
    for (int a = 8; a < 38; a++) if (a < 14 || a > 31) begin
      wr(4'h9, 2'h3, 6'(a), 16'($random(seed)));
      chk("slot", rcs_seen[3], sl(a));
      wr(4'h2, 2'h1, 6'(a), 16'($random(seed)));
      rd(4'h8, 2'h3, a, {4'hD, 8'h00, 16'(mi[3][sl(a)])});
      rd(4'h2, 2'h1, a, {4'hD, 8'h00, 15'(mg[1][sl(a)]), 1'b0});
    end
    $display("test force and compare done");
    cmd({1'b0, 4'h4, 2'h3, 6'h00, 16'hA5C3});
    chk("offset_dac", od_code, 16'hA5C3);
    chk("offset_load", ev_seen, 2'h1);
    cmd({1'b0, 4'h3, 2'h0, 22'h2ABCDE});
    chk("ctrl", {ctrl_ch, ctrl_d}, {4'h3, 22'h2ABCDE});
    chk("ctrl_wr", ev_seen, 2'h2);
    rd(4'h0, 2'h3, 6'h00, {4'hB, al});
    rd(4'h0, 2'h0, 6'h00, {4'h9, sc});
    rd(4'h0, 2'h1, 6'h00, {4'hA, cs});
    rd(4'h4, 2'h0, 6'h00, {4'hC, cr[2]});
    rd(4'h2, 2'h3, 6'h00, {4'hD, 8'h00, 16'hA5C3});
    $display("test offset, control and status done");
    summarize();
  end
endmodule
